// ---- eirq_asserts.sv ----
module eirq_asserts (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic vector_fetch_in,
  input wire logic cpu_int_mask_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pslverr_out,
  input wire logic irq_request_out,
  input wire logic [15:0] vector_addr_out,
  input wire logic ack_pulse_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  logic rd_c;
  logic wr_ack;
  // control word read and software acknowledge write in their access phase
  assign rd_c = psel_in && penable_in && !pwrite_in && paddr_in == 8'h00;
  assign wr_ack = psel_in && penable_in && pwrite_in && paddr_in == 8'h00 && pwdata_in[2];
  a_vec_pin: assert property (vector_addr_out == 16'hfffa)
    else $error("vector address wrong");
  a_vec_read: assert property (
    psel_in && penable_in && !pwrite_in && paddr_in == 8'h10 |-> prdata_out == 32'h0000fffa)
    else $error("vector read wrong");
  a_fetch_ack: assert property (vector_fetch_in && irq_request_out |=> ack_pulse_out)
    else $error("no ack after fetch");
  a_ack_cause: assert property (
    $rose(ack_pulse_out) |-> $past(vector_fetch_in) || $past(wr_ack))
    else $error("ack without cause");
  a_cpu_mask: assert property (cpu_int_mask_in |-> !irq_request_out)
    else $error("request passed cpu mask");
  a_mask_rd: assert property (rd_c && prdata_out[1] |-> !irq_request_out)
    else $error("request passed mask bit");
  a_ack_reads0: assert property (rd_c |-> !prdata_out[2])
    else $error("ack bit reads one");
  a_err_map: assert property (psel_in && penable_in && paddr_in[7:2] > 6'h4 |-> pslverr_out)
    else $error("unmapped access not refused");
  a_err_idle: assert property (!penable_in |-> !pslverr_out)
    else $error("error outside access");
  c_fetch: cover property (vector_fetch_in && irq_request_out);
  c_sw_ack: cover property (wr_ack);
  c_err: cover property (pslverr_out);
endmodule // eirq_asserts
bind eirq_top eirq_asserts u_eirq_asserts (.clk_sys_in, .rst_n_in, .vector_fetch_in,
  .cpu_int_mask_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
  .pslverr_out, .irq_request_out, .vector_addr_out, .ack_pulse_out);

// ---- eirq_evt_bank.sv ----
module eirq_evt_bank (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic enable_we_in,
  input wire logic clear_we_in,
  input wire logic [1:0] wdata_in,
  eirq_evt_if.bank evt
);
  typedef struct packed {
    logic [1:0] status;
    logic [1:0] enable;
  } eirq_bank_st_t;
  eirq_bank_st_t st_reg;
  eirq_bank_st_t st_next;
  // sticky status, a new event wins over a clear in the same cycle
  always_comb begin
    st_next = st_reg;
    if (clear_we_in) begin
      st_next.status = st_reg.status & ~wdata_in;
    end
    st_next.status = st_next.status | evt.event_pulse;
    if (enable_we_in) begin
      st_next.enable = wdata_in;
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= {eirq_pkg::eirq_rst_events, eirq_pkg::eirq_rst_events};
    end else begin
      st_reg <= st_next;
    end
  end
  assign evt.status = st_reg.status;
  assign evt.enable = st_reg.enable;
  assign evt.irq = |(st_reg.status & st_reg.enable);
endmodule // eirq_evt_bank

// ---- eirq_evt_if.sv ----
interface eirq_evt_if;
  logic [1:0] event_pulse;
  logic [1:0] status;
  logic [1:0] enable;
  logic irq;
  modport core (output event_pulse, input status, input irq);
  modport bank (input event_pulse, output status, output irq, output enable);
endinterface

// ---- eirq_pin_model.sv ----
module eirq_pin_model (
  input wire logic clk_sys_in,
  input wire logic req_in,
  input wire logic [3:0] lag_in,
  output logic pin_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] hist_reg = 16'h0;
  // device pulls the pin low lag_in+1 cycles after its request; released pin is pulled up
  always @(posedge clk_sys_in) hist_reg <= {hist_reg[14:0], req_in};
  assign pin_n_out = !hist_reg[lag_in];
endmodule // eirq_pin_model

// ---- eirq_pkg.sv ----
package eirq_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] eirq_off_status_control = 8'h00;
  localparam logic [7:0] eirq_off_int_status = 8'h04;
  localparam logic [7:0] eirq_off_int_enable = 8'h08;
  localparam logic [7:0] eirq_off_int_clear = 8'h0c;
  localparam logic [7:0] eirq_off_vector = 8'h10;
  // ext_int_status_control field positions
  localparam int eirq_bit_level = 0;
  localparam int eirq_bit_mask = 1;
  localparam int eirq_bit_ack = 2;
  localparam int eirq_bit_pending = 3;
  localparam int eirq_bit_pin = 4;
  // sticky event bits
  localparam int eirq_ev_latched = 0;
  localparam int eirq_ev_acked = 1;
  localparam int eirq_ev_num = 2;
  // values after reset
  localparam logic eirq_rst_level = 1'b0;
  localparam logic eirq_rst_mask = 1'b0;
  localparam logic eirq_rst_pin = 1'b1;
  localparam logic [1:0] eirq_rst_events = 2'h0;
  // vector locations for this source
  localparam logic [15:0] eirq_vector_hi_addr = 16'hfffa;
  localparam logic [15:0] eirq_vector_lo_addr = 16'hfffb;
endpackage

// ---- eirq_sync.sv ----
module eirq_sync (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic stage1;
    logic stage2;
  } eirq_sync_st_t;
  eirq_sync_st_t st_reg;
  eirq_sync_st_t st_next;
  // two flip-flop chain, the first stage read only by the second
  always_comb begin
    st_next.stage1 = async_in;
    st_next.stage2 = st_reg.stage1;
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= {eirq_pkg::eirq_rst_pin, eirq_pkg::eirq_rst_pin};
    end else begin
      st_reg <= st_next;
    end
  end
  assign sync_out = st_reg.stage2;
endmodule // eirq_sync

// ---- eirq_top.sv ----
// Operation
// - a request seen on the pin is held in one latch until cleared
// - vector fetch gives an acknowledge pulse that clears the latch
// - writing one to the ack bit clears the latch like a fetch
// - reset clears the latch and the level select bit
// - falling edge only by default; software may add low level
// - with level select set, falling edge and low level both set latch
// - edge only: latch holds until fetch, software clear or reset
// - edge and level: clears only after acknowledge and pin high
// - edge and level: acknowledge and pin high in either order
// - mask bit set withholds the request from the priority logic
// - cpu global mask flag also blocks the external request
// - a falling edge after an ack write sets the latch again
// - servicing the request loads pc from the two top vector bytes
module eirq_top (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic irq_pin_n_in,
  input wire logic vector_fetch_in,
  input wire logic cpu_int_mask_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic irq_request_out,
  output logic [15:0] vector_addr_out,
  output logic ack_pulse_out,
  output logic event_irq_out
);
  typedef struct packed {
    logic pin_prev;
    logic latch;
    logic ack_seen;
    logic level_sel;
    logic req_mask;
    logic ack_pulse;
    logic [31:0] rdata;
    logic slverr;
  } eirq_top_st_t;

  eirq_top_st_t st_reg;
  eirq_top_st_t st_next;
  logic pin_sync;
  logic fall_edge;
  logic low_level;
  logic sw_ack;
  logic ack_any;
  logic setting;
  logic wr_en;
  logic rd_en;
  logic [1:0] ev_pulse;
  eirq_evt_if evt ();

  //////////////////////////////////////////////////////////////////////////
  // pin synchroniser

  // pin sampled to the bus clock
  eirq_sync u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .async_in(irq_pin_n_in),
    .sync_out(pin_sync)
  );

  //////////////////////////////////////////////////////////////////////////
  // register decode helper

  // true when the access hits the given word offset
  function automatic logic eirq_hit(input logic [7:0] addr, input logic [7:0] off);
    eirq_hit = (addr[7:2] == off[7:2]);
  endfunction

  // apb access phase strobes, always one wait-free cycle
  assign wr_en = psel_in && penable_in && pwrite_in;
  assign rd_en = psel_in && penable_in && !pwrite_in;
  assign pready_out = 1'b1;

  //////////////////////////////////////////////////////////////////////////
  // detection and acknowledge

  // falling edge from current and previous synchronised sample
  assign fall_edge = st_reg.pin_prev && !pin_sync;
  assign low_level = st_reg.level_sel && !pin_sync;
  assign sw_ack = wr_en && eirq_hit(paddr_in, eirq_pkg::eirq_off_status_control)
    && pstrb_in[0] && pwdata_in[eirq_pkg::eirq_bit_ack];
  assign ack_any = sw_ack || vector_fetch_in;
  // edge always sets; low level only with level select
  assign setting = fall_edge || low_level;
  assign ev_pulse[eirq_pkg::eirq_ev_latched] = setting && !st_reg.latch;
  assign ev_pulse[eirq_pkg::eirq_ev_acked] = ack_any && st_reg.latch;
  assign evt.event_pulse = ev_pulse;

  //////////////////////////////////////////////////////////////////////////
  // next state

  // latch, acknowledge memory and register writes
  always_comb begin
    st_next = st_reg;
    st_next.pin_prev = pin_sync;
    st_next.ack_pulse = ack_any && st_reg.latch;
    if (st_reg.level_sel) begin
      // edge and level: both an ack and a high pin, either order
      if (ack_any && st_reg.latch) begin
        st_next.ack_seen = 1'b1;
      end
      if ((st_reg.ack_seen || ack_any) && pin_sync) begin
        st_next.latch = 1'b0;
        st_next.ack_seen = 1'b0;
      end
    end else begin
      st_next.ack_seen = 1'b0;
      if (ack_any) begin
        st_next.latch = 1'b0;
      end
    end
    // a set in the same cycle wins over any clear
    if (setting) begin
      st_next.latch = 1'b1;
      if (fall_edge) begin
        st_next.ack_seen = 1'b0;
      end
    end
    if (wr_en && eirq_hit(paddr_in, eirq_pkg::eirq_off_status_control) && pstrb_in[0]) begin
      st_next.level_sel = pwdata_in[eirq_pkg::eirq_bit_level];
      st_next.req_mask = pwdata_in[eirq_pkg::eirq_bit_mask];
    end
    st_next.rdata = 32'h0000_0000;
    st_next.slverr = 1'b0;
    if (psel_in && !penable_in) begin
      // read data prepared in setup, flagged error on unmapped words
      unique case (paddr_in[7:2])
        eirq_pkg::eirq_off_status_control[7:2]: begin
          st_next.rdata[eirq_pkg::eirq_bit_level] = st_reg.level_sel;
          st_next.rdata[eirq_pkg::eirq_bit_mask] = st_reg.req_mask;
          st_next.rdata[eirq_pkg::eirq_bit_pending] = st_reg.latch;
          st_next.rdata[eirq_pkg::eirq_bit_pin] = pin_sync;
        end
        eirq_pkg::eirq_off_int_status[7:2]: begin
          st_next.rdata[1:0] = evt.status;
        end
        eirq_pkg::eirq_off_int_enable[7:2]: begin
          st_next.rdata[1:0] = evt.enable;
        end
        eirq_pkg::eirq_off_int_clear[7:2]: begin
          st_next.rdata = 32'h0000_0000;
        end
        eirq_pkg::eirq_off_vector[7:2]: begin
          st_next.rdata[15:0] = eirq_pkg::eirq_vector_hi_addr;
        end
        default: begin
          st_next.slverr = 1'b1;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register

  // reset clears latch and level select even with the pin low
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg.pin_prev <= eirq_pkg::eirq_rst_pin;
      st_reg.latch <= 1'b0;
      st_reg.ack_seen <= 1'b0;
      st_reg.level_sel <= eirq_pkg::eirq_rst_level;
      st_reg.req_mask <= eirq_pkg::eirq_rst_mask;
      st_reg.ack_pulse <= 1'b0;
      st_reg.rdata <= 32'h0000_0000;
      st_reg.slverr <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // event status bank

  // sticky events with enables gating one level interrupt
  eirq_evt_bank u_bank (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .enable_we_in(wr_en && eirq_hit(paddr_in, eirq_pkg::eirq_off_int_enable) && pstrb_in[0]),
    .clear_we_in(wr_en && eirq_hit(paddr_in, eirq_pkg::eirq_off_int_clear) && pstrb_in[0]),
    .wdata_in(pwdata_in[1:0]),
    .evt(evt)
  );

  //////////////////////////////////////////////////////////////////////////
  // outputs

  // request gated by the local mask and the cpu global mask
  assign irq_request_out = st_reg.latch && !st_reg.req_mask
    && !cpu_int_mask_in;
  // vector high byte location; low byte follows at the next address
  assign vector_addr_out = eirq_pkg::eirq_vector_hi_addr;
  assign ack_pulse_out = st_reg.ack_pulse;
  assign event_irq_out = evt.irq;
  assign prdata_out = st_reg.rdata;
  assign pslverr_out = st_reg.slverr && psel_in && penable_in;
endmodule // eirq_top

// ---- tb_external_irq_latch.sv ----
module tb_external_irq_latch;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 1'h0, rst_n_in = 1'h0, fetch = 1'h0, cmask = 1'h0, req = 1'h0;
  logic psel = 1'h0, pen = 1'h0, pwr = 1'h0, r, er, pready, perr, irq, ack, evt, pin_n;
  logic [7:0] pa = 8'h0;
  logic [31:0] pwd = 32'h0, rd, prdata;
  logic [3:0] lag = 4'h0;
  logic [15:0] vec;
  int err_count = 0, checks = 0;
  always #2.5 clk_sys_in = !clk_sys_in;
  eirq_pin_model u_eirq_pin_model (.clk_sys_in, .req_in(req), .lag_in(lag), .pin_n_out(pin_n));
  eirq_top u_eirq_top (.clk_sys_in, .rst_n_in, .irq_pin_n_in(pin_n), .vector_fetch_in(fetch),
    .cpu_int_mask_in(cmask), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa),
    .pwdata_in(pwd), .pstrb_in(4'hf), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(perr), .irq_request_out(irq), .vector_addr_out(vec), .ack_pulse_out(ack),
    .event_irq_out(evt));
  // verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; read data and error taken at the completing edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    {psel, pwr, pa, pwd} <= {1'h1, w, a, d};
    @(posedge clk_sys_in);
    pen <= 1'h1;
    // sampled right at the edge, before that edge's own updates land
    do begin
      @(posedge clk_sys_in);
      n++;
      {r, rd, er} = {pready, prdata, perr};
    end while (r !== 1'h1 && n < 20);
    {psel, pen} <= 2'h0;
    if (r !== 1'h1) begin
      err_count++;
      $display("[ERR] %0t bus timeout", $time);
      final_report();
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask
  // bounded wait for the request level, then compare
  task automatic wirq(input logic v);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys_in);
      n++;
    end while (irq !== v && n < 16);
    chk(irq, v);
    if (irq !== v) final_report();
  endtask
  task automatic hold(input logic v);
    repeat (6) begin
      @(negedge clk_sys_in);
      chk(irq, v);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_sys_in);
    rst_n_in <= 1'h1;
    rdc(8'h00, 32'h10);
    @(posedge clk_sys_in) req <= 1'h1;
    wirq(1'h1);
    @(posedge clk_sys_in) req <= 1'h0;
    hold(1'h1);
    @(posedge clk_sys_in) fetch <= 1'h1;
    @(posedge clk_sys_in) fetch <= 1'h0;
    @(negedge clk_sys_in);
    chk(ack, 1'h1);
    chk(irq, 1'h0);
    rdc(8'h10, 32'h0000fffa);
    chk(vec, 16'hfffa);
    @(posedge clk_sys_in) req <= 1'h1;
    wirq(1'h1);
    @(posedge clk_sys_in) req <= 1'h0;
    apb(1'h1, 8'h00, 32'h4);
    wirq(1'h0);
    @(posedge clk_sys_in) req <= 1'h1;
    wirq(1'h1);
    $display("edge test done");
    // level select first, so the later ack meets level mode with the pin still low
    apb(1'h1, 8'h00, 32'h1);
    hold(1'h1);
    @(posedge clk_sys_in) lag <= 4'h5;
    apb(1'h1, 8'h00, 32'h5);
    hold(1'h1);
    @(posedge clk_sys_in) req <= 1'h0;
    wirq(1'h0);
    @(posedge clk_sys_in) {lag, req} <= {4'h0, 1'h1};
    wirq(1'h1);
    @(posedge clk_sys_in) req <= 1'h0;
    hold(1'h1);
    @(posedge clk_sys_in) fetch <= 1'h1;
    @(posedge clk_sys_in) fetch <= 1'h0;
    wirq(1'h0);
    $display("level test done");
    apb(1'h1, 8'h00, 32'h2);
    @(posedge clk_sys_in) req <= 1'h1;
    hold(1'h0);
    rdc(8'h00, 32'h0a);
    @(posedge clk_sys_in) {req, cmask} <= 2'h1;
    apb(1'h1, 8'h00, 32'h0);
    hold(1'h0);
    @(posedge clk_sys_in) cmask <= 1'h0;
    wirq(1'h1);
    $display("mask test done");
    rdc(8'h04, 32'h3);
    apb(1'h1, 8'h08, 32'h3);
    rdc(8'h08, 32'h3);
    @(negedge clk_sys_in);
    chk(evt, 1'h1);
    apb(1'h1, 8'h08, 32'h0);
    @(negedge clk_sys_in);
    chk(evt, 1'h0);
    apb(1'h1, 8'h0c, 32'h3);
    rdc(8'h04, 32'h0);
    rdc(8'h0c, 32'h0);
    rdc(8'h20, 32'h0);
    chk(er, 1'h1);
    $display("event test done");
    // clear the latch, enter level mode, then hold the pin low into reset
    apb(1'h1, 8'h00, 32'h5);
    wirq(1'h0);
    @(posedge clk_sys_in) req <= 1'h1;
    wirq(1'h1);
    @(posedge clk_sys_in) rst_n_in <= 1'h0;
    @(negedge clk_sys_in);
    chk(irq, 1'h0);
    @(posedge clk_sys_in) rst_n_in <= 1'h1;
    apb(1'h0, 8'h00, 32'h0);
    chk(rd[0], 1'h0);
    $display("reset test done");
    final_report();
  end
endmodule // tb_external_irq_latch
